/* shared/cpd_consts.vh */
// Functional notes
// - Request 11b starts automatic analysis of all ten pair combinations.
// - Upper request bit self-clears at completion; lower bit then flags valid results.
// - Request reads 11b auto running, 10b single running, 01b done valid.
// - Single mode: launch select 00b..11b picks pair A..D for launching.
// - Auto mode: launch select picks the first pair reported, not a launcher.
// - Single mode: listen select picks listening pair; ignored in auto mode.
// - After auto analysis each result read reports the next pair.
// - Fault class: 11b invalid, 10b open/short, 01b mismatch, 00b good.
// - Open/short with no cross-short bits is an open, else shorted pairs.
// - Invalid result forces distance to 0xFF.
// - Auto result reads step the pair A, B, C, D per read and wrap to A.
// - Pair indicator names the pair owning the readable class, shorts, distance.
// - Cross-short bits D, C, B and A read 1b when shorted to that pair.
// - Eight-bit distance in metres to first fault; all ones means unknown.
// - Pair indicator encodes A 00b, B 01b, C 10b, D 11b.
`ifndef CPD_CONSTS_VH
`define CPD_CONSTS_VH

// Register addresses
`define CPD_ADDR_W          5
`define CPD_ADDR_CTRL       5'h1E
`define CPD_ADDR_RESULT     5'h1F
`define CPD_ADDR_IRQ_STAT   5'h1A
`define CPD_ADDR_IRQ_CLR    5'h1B
`define CPD_ADDR_IRQ_EN     5'h1C

// Field positions
`define CPD_REQ_HI          15
`define CPD_REQ_LO          14
`define CPD_LAUNCH_HI       13
`define CPD_LAUNCH_LO       12
`define CPD_LISTEN_HI       11
`define CPD_LISTEN_LO       10
`define CPD_SHORT_HI        13
`define CPD_SHORT_LO        10
`define CPD_DIST_HI         9
`define CPD_DIST_LO         2
`define CPD_PAIR_HI         1
`define CPD_PAIR_LO         0

// Request codes
`define CPD_REQ_AUTO        2'h3
`define CPD_REQ_SINGLE      2'h2
`define CPD_REQ_DONE_OK     2'h1
`define CPD_REQ_RESET       2'h0

// Fault classes
`define CPD_CLASS_INVALID   2'h3
`define CPD_CLASS_OPEN_SHORT 2'h2
`define CPD_CLASS_MISMATCH  2'h1
`define CPD_CLASS_GOOD      2'h0
`define CPD_DIST_UNKNOWN    8'hFF

// Pair codes
`define CPD_PAIR_A          2'h0
`define CPD_PAIR_D          2'h3

// Interrupt bits
`define CPD_IRQ_W           3
`define CPD_IRQ_DONE        0
`define CPD_IRQ_FAULT       1
`define CPD_IRQ_INVALID     2
`define CPD_IRQ_RESET       3'h0

// Measurement watchdog, in clock cycles
`define CPD_MEAS_TIMEOUT_CYC 65535

`endif

/* design/cpd_pair_store.v */
`timescale 1ns/1ps
`default_nettype none
`include "cpd_consts.vh"

// Result store for one cable pair
module cpd_pair_store #(
  parameter DIST_W = 8
) (
  input  wire              mclk,
  input  wire              rst_sync_b,
  input  wire              clear,
  input  wire              res_we,
  input  wire [1:0]        res_class,
  input  wire [DIST_W-1:0] res_dist,
  input  wire [3:0]        short_set,
  output reg  [1:0]        fault_class,
  output reg  [DIST_W-1:0] fault_distance_m,
  output reg  [3:0]        cross_short
);

  // Class defaults to invalid; shorts accumulate over the run
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fault_class      <= `CPD_CLASS_INVALID;
      fault_distance_m <= {DIST_W{1'b1}};
      cross_short      <= 4'h0;
    end else if (clear) begin
      fault_class      <= `CPD_CLASS_INVALID;
      fault_distance_m <= {DIST_W{1'b1}};
      cross_short      <= 4'h0;
    end else begin
      if (res_we) begin
        fault_class <= res_class;
        if (res_class == `CPD_CLASS_INVALID) begin
          fault_distance_m <= {DIST_W{1'b1}};
        end else begin
          fault_distance_m <= res_dist;
        end
      end
      cross_short <= cross_short | short_set;
    end
  end

endmodule // cpd_pair_store
`default_nettype wire

/* design/cpd_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "cpd_consts.vh"

// Cable pair reflectometry control and result reporting
module cpd_ctrl #(
  parameter MEAS_TIMEOUT_CYC = `CPD_MEAS_TIMEOUT_CYC
) (
  input  wire                   mclk,
  input  wire                   rst_b,
  input  wire [`CPD_ADDR_W-1:0] reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_we,
  input  wire                   reg_re,
  output reg  [15:0]            reg_rdata,
  output reg                    irq,
  output reg                    meas_start,
  output reg  [1:0]             meas_launch_pair,
  output reg  [1:0]             meas_listen_pair,
  input  wire                   meas_done,
  input  wire [1:0]             meas_class,
  input  wire [7:0]             meas_dist
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_LAUNCH = 2'h1;
  localparam [1:0] ST_WAIT   = 2'h2;

  // Reset synchroniser
  reg                  rst_q1;
  reg                  rst_sync_b;

  // Software-visible control fields
  reg  [1:0]           cable_test_request;
  reg  [1:0]           launch_pair_select;
  reg  [1:0]           listen_pair_select;

  // Sequencer, current combination and read pointer
  reg  [1:0]           state;
  reg                  auto_run;
  reg                  last_auto;
  reg  [1:0]           cur_tx;
  reg  [1:0]           cur_rx;
  reg  [1:0]           rd_ptr;
  reg  [31:0]          wd_cnt;
  reg                  store_clear;

  // Interrupt registers and read-back word
  reg  [`CPD_IRQ_W-1:0] irq_stat;
  reg  [`CPD_IRQ_W-1:0] irq_en;
  reg  [`CPD_IRQ_W-1:0] next_irq_stat;
  reg  [`CPD_IRQ_W-1:0] next_irq_en;
  reg  [`CPD_IRQ_W-1:0] irq_set;
  reg  [15:0]          next_rdata;

  // Register strobes
  wire                 ctrl_wr;
  wire                 start_req;
  wire                 res_rd;
  wire                 irq_clr_wr;
  wire                 irq_en_wr;

  // Measurement capture and pair decode
  wire                 wd_hit;
  wire                 rec_valid;
  wire [1:0]           rec_class;
  wire [7:0]           rec_dist;
  wire                 self_comb;
  wire                 cross_short;
  wire                 cross_keep;
  wire                 last_comb;
  wire                 auto_more;

  // Per-pair store outputs and the selected pair
  wire [7:0]           st_class;
  wire [31:0]          st_dist;
  wire [15:0]          st_short;
  wire [1:0]           sel_class;
  wire [7:0]           sel_dist;
  wire [3:0]           sel_short;

  // Reset release through two flops
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_sync_b <= rst_q1;
    end
  end

  // Request decode; control writes and result reads only taken while idle
  assign ctrl_wr   = reg_we && (reg_addr == `CPD_ADDR_CTRL) && (state == ST_IDLE);
  assign start_req = ctrl_wr && reg_wdata[`CPD_REQ_HI];
  assign res_rd     = reg_re && (reg_addr == `CPD_ADDR_RESULT) && (state == ST_IDLE);
  assign irq_clr_wr = reg_we && (reg_addr == `CPD_ADDR_IRQ_CLR);
  assign irq_en_wr  = reg_we && (reg_addr == `CPD_ADDR_IRQ_EN);

  // Measurement result, watchdog turns a silent front end into invalid
  assign wd_hit    = (state == ST_WAIT) && !meas_done && (wd_cnt == MEAS_TIMEOUT_CYC - 1);
  assign rec_valid = (state == ST_WAIT) && (meas_done || wd_hit);
  assign rec_class = wd_hit ? `CPD_CLASS_INVALID : meas_class;
  assign rec_dist  = wd_hit ? `CPD_DIST_UNKNOWN : meas_dist;
  assign self_comb = (cur_tx == cur_rx);
  assign cross_short = !self_comb && (rec_class == `CPD_CLASS_OPEN_SHORT);
  assign cross_keep  = cross_short || (rec_class == `CPD_CLASS_INVALID);
  assign last_comb   = (cur_tx == `CPD_PAIR_D) && (cur_rx == `CPD_PAIR_D);
  assign auto_more   = auto_run && !last_comb;

  // One result store per pair
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pair
      // Pair index cut to the select width
      localparam [31:0] PIDX_FULL = g;
      localparam [1:0]  PIDX      = PIDX_FULL[1:0];
      wire       hit_tx = (cur_tx == PIDX);
      wire       hit_rx = (cur_rx == PIDX);
      wire       we     = rec_valid && (hit_tx || hit_rx) && (self_comb || cross_keep);
      wire [3:0] sset   = (rec_valid && cross_short) ?
                          ((hit_tx ? (4'h1 << cur_rx) : 4'h0) |
                           (hit_rx ? (4'h1 << cur_tx) : 4'h0)) : 4'h0;
      cpd_pair_store #(
        .DIST_W (8)
      ) u_store (
        .mclk             (mclk),
        .rst_sync_b       (rst_sync_b),
        .clear            (store_clear),
        .res_we           (we),
        .res_class        (rec_class),
        .res_dist         (rec_dist),
        .short_set        (sset),
        .fault_class      (st_class[2*g +: 2]),
        .fault_distance_m (st_dist[8*g +: 8]),
        .cross_short      (st_short[4*g +: 4])
      );
    end
  endgenerate

  // Sequencer over pair combinations
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state              <= ST_IDLE;
      cable_test_request <= `CPD_REQ_RESET;
      launch_pair_select <= `CPD_PAIR_A;
      listen_pair_select <= `CPD_PAIR_A;
      auto_run           <= 1'b0;
      last_auto          <= 1'b0;
      cur_tx             <= `CPD_PAIR_A;
      cur_rx             <= `CPD_PAIR_A;
      store_clear        <= 1'b0;
      meas_start         <= 1'b0;
      meas_launch_pair   <= `CPD_PAIR_A;
      meas_listen_pair   <= `CPD_PAIR_A;
      wd_cnt             <= 32'h0;
    end else begin
      store_clear <= 1'b0;
      meas_start  <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Selects follow any idle control write
          if (ctrl_wr) begin
            launch_pair_select <= reg_wdata[`CPD_LAUNCH_HI:`CPD_LAUNCH_LO];
            listen_pair_select <= reg_wdata[`CPD_LISTEN_HI:`CPD_LISTEN_LO];
          end
          if (start_req) begin
            cable_test_request <= reg_wdata[`CPD_REQ_HI:`CPD_REQ_LO];
            store_clear        <= 1'b1;
            state              <= ST_LAUNCH;
            if (reg_wdata[`CPD_REQ_LO]) begin
              // Auto walks all ten combinations from A,A
              auto_run  <= 1'b1;
              last_auto <= 1'b1;
              cur_tx    <= `CPD_PAIR_A;
              cur_rx    <= `CPD_PAIR_A;
            end else begin
              auto_run  <= 1'b0;
              last_auto <= 1'b0;
              cur_tx    <= reg_wdata[`CPD_LAUNCH_HI:`CPD_LAUNCH_LO];
              cur_rx    <= reg_wdata[`CPD_LISTEN_HI:`CPD_LISTEN_LO];
            end
          end
        end
        ST_LAUNCH: begin
          meas_start       <= 1'b1;
          meas_launch_pair <= cur_tx;
          meas_listen_pair <= cur_rx;
          wd_cnt           <= 32'h0;
          state            <= ST_WAIT;
        end
        ST_WAIT: begin
          // Watchdog counts cycles since the launch
          wd_cnt <= wd_cnt + 32'h1;
          // A record steps to the next combination or ends the run
          if (rec_valid) begin
            if (auto_more) begin
              // Next combination with listen pair at or above launch pair
              if (cur_rx == `CPD_PAIR_D) begin
                cur_tx <= cur_tx + 2'h1;
                cur_rx <= cur_tx + 2'h1;
              end else begin
                cur_rx <= cur_rx + 2'h1;
              end
              state <= ST_LAUNCH;
            end else begin
              cable_test_request <= `CPD_REQ_DONE_OK;
              state              <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Result read pointer, restarted by each request
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_ptr <= `CPD_PAIR_A;
    end else if (start_req) begin
      rd_ptr <= reg_wdata[`CPD_LAUNCH_HI:`CPD_LAUNCH_LO];
    end else if (res_rd && last_auto) begin
      rd_ptr <= rd_ptr + 2'h1;
    end
  end

  // Selected pair's stored result
  assign sel_class = st_class[{rd_ptr, 1'b0} +: 2];
  assign sel_dist  = st_dist[{rd_ptr, 3'b000} +: 8];
  assign sel_short = st_short[{rd_ptr, 2'b00} +: 4];

  // Interrupt status, enable and clear; a set beats a clear
  always @* begin
    irq_set = `CPD_IRQ_RESET;
    if ((state == ST_WAIT) && rec_valid) begin
      irq_set[`CPD_IRQ_DONE]    = !auto_more;
      irq_set[`CPD_IRQ_FAULT]   = (rec_class == `CPD_CLASS_OPEN_SHORT) ||
                                  (rec_class == `CPD_CLASS_MISMATCH);
      irq_set[`CPD_IRQ_INVALID] = (rec_class == `CPD_CLASS_INVALID);
    end
    // Clear first; this cycle's events then set again
    next_irq_stat = irq_stat;
    if (irq_clr_wr) begin
      next_irq_stat = irq_stat & ~reg_wdata[`CPD_IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
    next_irq_en = irq_en;
    if (irq_en_wr) begin
      next_irq_en = reg_wdata[`CPD_IRQ_W-1:0];
    end
  end

  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_stat <= `CPD_IRQ_RESET;
      irq_en   <= `CPD_IRQ_RESET;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
      irq      <= |(next_irq_stat & next_irq_en);
    end
  end

  // Read data mux
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `CPD_ADDR_CTRL: begin
        next_rdata[`CPD_REQ_HI:`CPD_REQ_LO]       = cable_test_request;
        next_rdata[`CPD_LAUNCH_HI:`CPD_LAUNCH_LO] = launch_pair_select;
        next_rdata[`CPD_LISTEN_HI:`CPD_LISTEN_LO] = listen_pair_select;
      end
      `CPD_ADDR_RESULT: begin
        next_rdata[`CPD_REQ_HI:`CPD_REQ_LO]     = sel_class;
        next_rdata[`CPD_SHORT_HI:`CPD_SHORT_LO] = sel_short;
        next_rdata[`CPD_DIST_HI:`CPD_DIST_LO]   = sel_dist;
        next_rdata[`CPD_PAIR_HI:`CPD_PAIR_LO]   = rd_ptr;
      end
      `CPD_ADDR_IRQ_STAT: begin
        next_rdata[`CPD_IRQ_W-1:0] = irq_stat;
      end
      `CPD_ADDR_IRQ_EN: begin
        next_rdata[`CPD_IRQ_W-1:0] = irq_en;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data held until the next read
  always @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_re) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // cpd_ctrl
`default_nettype wire

/* tb/cpd_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpd_consts.vh"
// Port-level checks on the reflectometry controller
module cpd_sva #(
  parameter MEAS_TIMEOUT_CYC = 16
) (
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic [`CPD_ADDR_W-1:0] reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_we,
  input wire logic                   reg_re,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   irq,
  input wire logic                   meas_start,
  input wire logic [1:0]             meas_launch_pair,
  input wire logic [1:0]             meas_listen_pair,
  input wire logic                   meas_done,
  input wire logic [1:0]             meas_class,
  input wire logic [7:0]             meas_dist
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire start_wr = reg_we && reg_addr == `CPD_ADDR_CTRL && reg_wdata[15];
  logic [31:0] quiet;
  // Cycles since the front end last moved, for the watchdog path
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) quiet <= 32'h0;
    else if (meas_start || meas_done) quiet <= 32'h0;
    else quiet <= quiet + 32'h1;
  end
  property p_start_pulse; meas_start |=> !meas_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start strobe longer than one cycle");
  property p_start_cause;
    meas_start |-> $past(meas_done, 2) || $past(start_wr, 2) ||
      $past(quiet, 2) == MEAS_TIMEOUT_CYC - 2;
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start strobe without a cause");
  property p_single_pairs;
    start_wr && !reg_wdata[14] ##2 meas_start |->
      meas_launch_pair == $past(reg_wdata[13:12], 2) &&
      meas_listen_pair == $past(reg_wdata[11:10], 2);
  endproperty
  a_single_pairs: assert property (p_single_pairs)
    else $error("single run uses wrong pairs");
  property p_auto_first;
    start_wr && reg_wdata[14] ##2 meas_start |-> meas_launch_pair == 2'h0 && meas_listen_pair == 2'h0;
  endproperty
  a_auto_first: assert property (p_auto_first)
    else $error("automatic run does not begin with pair A to A");
  property p_pairs_hold; !meas_start |-> $stable(meas_launch_pair) && $stable(meas_listen_pair);
  endproperty
  a_pairs_hold: assert property (p_pairs_hold)
    else $error("pair selects moved without a start");
  property p_rdata_hold; !$past(reg_re) |-> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_invalid_dist;
    $past(reg_re && reg_addr == `CPD_ADDR_RESULT) && reg_rdata[15:14] == `CPD_CLASS_INVALID
      |-> reg_rdata[9:2] == `CPD_DIST_UNKNOWN;
  endproperty
  a_invalid_dist: assert property (p_invalid_dist)
    else $error("invalid result with a real distance");
  property p_req_auto;
    start_wr && reg_wdata[14] ##1 reg_re && reg_addr == `CPD_ADDR_CTRL
      |=> reg_rdata[15:14] == `CPD_REQ_AUTO;
  endproperty
  a_req_auto: assert property (p_req_auto)
    else $error("running automatic request not shown");
  property p_unmapped; reg_re && reg_addr < 5'h1A |=> reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // cpd_sva
`default_nettype wire

/* tb/cpd_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Cable front end: answers each launch after a delay, or stays mute
module cpd_front_model (
  input wire logic        mclk,
  input wire logic        meas_start,
  input wire logic [1:0]  launch,
  input wire logic [1:0]  listen,
  input wire logic [31:0] cls_map,
  input wire logic [15:0] mute_map,
  input wire logic [3:0]  delay,
  output var logic        meas_done,
  output var logic [1:0]  meas_class,
  output var logic [7:0]  meas_dist
);
  logic [3:0] idx;
  logic [3:0] cnt;
  logic       armed;
  initial begin
    meas_done = 1'b0; meas_class = 2'h0; meas_dist = 8'h00; armed = 1'b0; cnt = 4'h0;
  end
  // Result lines toggle outside the strobe so stale values never match
  always @(posedge mclk) begin
    meas_done <= 1'b0;
    meas_class <= ~meas_class;
    meas_dist <= ~meas_dist;
    if (meas_start) begin
      idx <= {launch, listen};
      cnt <= delay;
      armed <= !mute_map[{launch, listen}];
    end else if (armed && cnt == 4'h0) begin
      armed <= 1'b0;
      meas_done <= 1'b1;
      meas_class <= cls_map[2*idx +: 2];
      meas_dist <= {4'h3, idx};
    end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule // cpd_front_model
`default_nettype wire

/* tb/cpd_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpd_consts.vh"
`define CPD_CMP(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module cpd_ctrl_tb_top;
  typedef struct {logic [15:0] v; bit chk; string n;} cpd_note_t;
  logic mclk = 1'b0, rst_b, reg_we, reg_re, rd_seen;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, last_rd, exp;
  logic [31:0] cls_map;
  logic [15:0] mute_map;
  logic [3:0] delay;
  logic [1:0] tx, rx, c, l;
  wire [15:0] reg_rdata;
  wire irq, meas_start, meas_done;
  wire [1:0] launch, listen, meas_class;
  wire [7:0] meas_dist;
  int failures, checked, seed, s, k;
  cpd_note_t notes[$];
  cpd_note_t cur;
  always #10 mclk = ~mclk;
  cpd_ctrl #(.MEAS_TIMEOUT_CYC(16)) uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
    .meas_start(meas_start), .meas_launch_pair(launch), .meas_listen_pair(listen),
    .meas_done(meas_done), .meas_class(meas_class), .meas_dist(meas_dist));
  cpd_front_model u_front (.mclk(mclk), .meas_start(meas_start), .launch(launch),
    .listen(listen), .cls_map(cls_map), .mute_map(mute_map), .delay(delay),
    .meas_done(meas_done), .meas_class(meas_class), .meas_dist(meas_dist));
  // Read data monitor: oldest note against the answer
  always @(posedge mclk) begin
    if (rd_seen) begin
      last_rd <= reg_rdata;
      cur = notes.pop_front();
      if (cur.chk) `CPD_CMP(cur.n, cur.v, reg_rdata)
    end
    rd_seen <= reg_re;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk); reg_we <= 1'b1; reg_re <= 1'b0; reg_addr <= a; reg_wdata <= d;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input bit ck, input string n);
    @(posedge mclk); reg_re <= 1'b1; reg_we <= 1'b0; reg_addr <= a; notes.push_back('{e, ck, n});
    reg_wdata <= 16'($random(seed));
  endtask
  task idle;
    @(posedge mclk); reg_re <= 1'b0; reg_we <= 1'b0;
  endtask
  task check_irq(input logic e);
    idle; repeat (2) @(posedge mclk);
    `CPD_CMP("irq", e, irq)
  endtask
  // Poll the request field until the run finishes
  task automatic wait_done;
    for (int i = 0; i < 300; i++) begin
      rd(`CPD_ADDR_CTRL, 16'h0, 1'b0, "poll"); idle; repeat (2) @(posedge mclk);
      if (last_rd[15] === 1'b0) return;
    end
    failures++;
    conclude;
  endtask
  function automatic logic [15:0] auto_exp(input logic [1:0] p);
    return (p == 2'h3) ? 16'hC3FF : {p, 4'h0, 4'h3, p, p, p};
  endfunction
  task conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    seed = 79; failures = 0; checked = 0; rst_b = 1'b0; reg_we = 1'b0; reg_re = 1'b0;
    reg_addr = 5'h00; reg_wdata = 16'h0000; rd_seen = 1'b0; last_rd = 16'h0000;
    cls_map = 32'h00200400; mute_map = 16'h8000; delay = 4'h0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset synchroniser has released, so requests are legal from here on
    repeat (3) @(posedge mclk);
    rd(`CPD_ADDR_CTRL, 16'h0000, 1'b1, "control");
    rd(`CPD_ADDR_RESULT, 16'hC3FC, 1'b1, "result");
    rd(`CPD_ADDR_IRQ_STAT, 16'h0000, 1'b1, "status");
    rd(5'h05, 16'h0000, 1'b1, "unmapped");
    // Automatic runs, each first pair, with a refused write mid-run
    for (s = 0; s < 4; s++) begin
      delay <= 4'({$random(seed)} % 13);
      l = 2'($random(seed));
      wr(`CPD_ADDR_CTRL, {2'b11, 2'(s), l, 10'h0});
      rd(`CPD_ADDR_CTRL, {2'b11, 2'(s), l, 10'h0}, 1'b1, "control");
      wr(`CPD_ADDR_CTRL, 16'h8000);
      rd(`CPD_ADDR_CTRL, {2'b11, 2'(s), l, 10'h0}, 1'b1, "control");
      idle;
      wait_done;
      rd(`CPD_ADDR_CTRL, {2'b01, 2'(s), l, 10'h0}, 1'b1, "control");
      for (k = 0; k < 5; k++) rd(`CPD_ADDR_RESULT, auto_exp(2'(s + k)), 1'b1, "result");
      if (s == 0) begin
        rd(`CPD_ADDR_IRQ_STAT, 16'h0007, 1'b1, "status");
        wr(`CPD_ADDR_IRQ_STAT, 16'h0000);
        rd(`CPD_ADDR_IRQ_STAT, 16'h0007, 1'b1, "status");
        check_irq(1'b0);
        wr(`CPD_ADDR_IRQ_EN, 16'h0007);
        check_irq(1'b1);
        rd(`CPD_ADDR_IRQ_EN, 16'h0007, 1'b1, "enable");
        rd(`CPD_ADDR_IRQ_CLR, 16'h0000, 1'b1, "clear");
        wr(`CPD_ADDR_IRQ_CLR, 16'h0007);
        check_irq(1'b0);
        rd(`CPD_ADDR_IRQ_STAT, 16'h0000, 1'b1, "status");
      end
      idle;
    end
    // Single runs: cross shorts, self classes, one run with every pair mute
    for (k = 0; k < 7; k++) begin
      tx = 2'(k);
      rx = (k < 4) ? 2'(3 - k) : tx;
      c = (k < 4) ? 2'b10 : 2'($random(seed));
      cls_map <= 32'(c) << (2 * {tx, rx});
      mute_map <= (k == 6) ? 16'hFFFF : 16'h0000;
      delay <= 4'({$random(seed)} % 13);
      exp = (k == 6 || c == 2'b11) ? {2'b11, 4'h0, 8'hFF, tx} :
            {c, (k < 4) ? 4'(1 << rx) : 4'h0, 4'h3, tx, rx, tx};
      wr(`CPD_ADDR_CTRL, {2'b10, tx, rx, 10'h0});
      rd(`CPD_ADDR_CTRL, {2'b10, tx, rx, 10'h0}, 1'b1, "control");
      idle;
      wait_done;
      rd(`CPD_ADDR_RESULT, exp, 1'b1, "result");
      rd(`CPD_ADDR_RESULT, exp, 1'b1, "result");
      idle;
    end
    // Idle select-only write and a write to the result word change no results
    wr(`CPD_ADDR_CTRL, 16'h2400);
    wr(`CPD_ADDR_RESULT, 16'h0000);
    rd(`CPD_ADDR_CTRL, 16'h6400, 1'b1, "control");
    rd(`CPD_ADDR_RESULT, 16'hC3FE, 1'b1, "result");
    idle;
    repeat (4) @(posedge mclk);
    conclude;
  end
endmodule // cpd_ctrl_tb_top
bind cpd_ctrl cpd_sva #(.MEAS_TIMEOUT_CYC(MEAS_TIMEOUT_CYC)) u_sva (.mclk(mclk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .irq(irq), .meas_start(meas_start),
  .meas_launch_pair(meas_launch_pair), .meas_listen_pair(meas_listen_pair),
  .meas_done(meas_done), .meas_class(meas_class), .meas_dist(meas_dist));
`default_nettype wire
